/* common/isx_pkg.sv */
// Constants, types and helpers shared by the instruction execute block
//
// Behaviour
// (RL1) Increment-and-skip adds one to the file operand and writes it to the accumulator when the direction bit is 0, or back to the file register when it is 1, touching no flag.
// (RL2) When that sum is zero the prefetched next instruction is discarded and run as a no-operation, so it takes two cycles; otherwise one.
// (RL3) Increment-and-skip decodes from 00 1111, then the direction bit, then a seven-bit file address 0 to 127.
// (RL4) OR-with-file ORs the accumulator with the file operand, writes to the accumulator for direction 0 or the file register for 1, and updates the zero flag.
// (RL5) OR-with-file decodes from 00 0100, then the direction bit and seven-bit address, and completes in one cycle.
// (RL6) Load-literal copies an unsigned eight-bit immediate 0 to 255 unchanged into the accumulator.
// (RL7) Load-literal decodes from 11 00, two ignored bits and the literal, affects no flag and takes one cycle.
// (RL8) Whenever the zero flag is affected it is set for an all-zero result and cleared otherwise.
package isx_pkg;
   // ****************************************
   // Widths and field positions
   // ****************************************
   localparam int INSTR_W  = 14;
   localparam int DATA_W   = 8;
   localparam int ADDR_W   = 7;
   localparam int DIR_BIT  = 7;
   localparam int ADDR_MSB = 6;
   localparam int LIT_MSB  = 7;
   localparam int OPC6_LSB = 8;
   localparam int OPC4_LSB = 10;
   // ****************************************
   // Opcode patterns
   // ****************************************
   localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
   localparam logic [5:0] OPC_OR_FILE  = 6'h04;
   localparam logic [3:0] OPC_LOAD_LIT = 4'hc;
   // ****************************************
   // Reset values and the increment step
   // ****************************************
   localparam logic [7:0] ACC_RST  = 8'h00;
   localparam logic       ZERO_RST = 1'b0;
   localparam logic [7:0] ONE      = 8'h01;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      OP_NONE = 4'b0001,
      OP_INC  = 4'b0010,
      OP_OR   = 4'b0100,
      OP_LIT  = 4'b1000
   } isx_op_t;
   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_SKIP = 2'b10
   } isx_state_t;

   function automatic logic f_is_zero(input logic [7:0] v);
      return (v == 8'h00);
   endfunction
endpackage

/* common/isx_dec_if.sv */
// Interface between the execute block and its instruction decoder
`timescale 1ns/1ps
`default_nettype none
interface isx_dec_if;
   logic [13:0]      instr;
   isx_pkg::isx_op_t op;
   logic             dir;
   logic [6:0]       addr;
   logic [7:0]       lit;
   modport decoder (input instr, output op, output dir, output addr, output lit);
   modport user    (output instr, input op, input dir, input addr, input lit);
endinterface
`default_nettype wire

/* rtl/isx_decode.sv */
// Instruction word decoder for the execute block
`timescale 1ns/1ps
`default_nettype none
module isx_decode (
   // Decoded fields
   isx_dec_if.decoder dec
);
   always_comb begin
      dec.dir  = dec.instr[isx_pkg::DIR_BIT];
      dec.addr = dec.instr[isx_pkg::ADDR_MSB:0];
      dec.lit  = dec.instr[isx_pkg::LIT_MSB:0];
      // The two literal don't-care bits are not checked
      if (dec.instr[13:isx_pkg::OPC6_LSB] == isx_pkg::OPC_INC_SKIP) begin //RL3
         dec.op = isx_pkg::OP_INC;
      end else if (dec.instr[13:isx_pkg::OPC6_LSB] == isx_pkg::OPC_OR_FILE) begin //RL5
         dec.op = isx_pkg::OP_OR;
      end else if (dec.instr[13:isx_pkg::OPC4_LSB] == isx_pkg::OPC_LOAD_LIT) begin //RL7
         dec.op = isx_pkg::OP_LIT;
      end else begin
         dec.op = isx_pkg::OP_NONE;
      end
   end
endmodule
`default_nettype wire

/* rtl/isx_exec.sv */
// Execute stage for increment-skip, OR-with-file and load-literal
`timescale 1ns/1ps
`default_nettype none
module isx_exec (
   // Clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        RST_N_IN,
   // Fetch pipeline
   input  wire logic        INSTR_VALID_IN,
   input  wire logic [13:0] INSTR_IN,
   input  wire logic [7:0]  FILE_DATA_IN,
   // File register write port
   output logic             FILE_WE_OUT,
   output logic [6:0]       FILE_WADDR_OUT,
   output logic [7:0]       FILE_WDATA_OUT,
   // Core state and pipeline control
   output logic [7:0]       ACC_OUT,
   output logic             ZERO_FLAG_OUT,
   output logic             FLUSH_OUT,
   output logic             DONE_OUT,
   output logic             UNSUPPORTED_OUT
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      isx_pkg::isx_state_t state;
      logic [7:0]          acc;
      logic                zero;
      logic                we;
      logic [6:0]          waddr;
      logic [7:0]          wdata;
      logic                flush;
      logic                done;
      logic                unsup;
   } isx_regs_t;

   localparam isx_regs_t REGS_RST = '{
      state: isx_pkg::ST_RUN,
      acc:   isx_pkg::ACC_RST,
      zero:  isx_pkg::ZERO_RST,
      we:    1'b0,
      waddr: 7'h00,
      wdata: 8'h00,
      flush: 1'b0,
      done:  1'b0,
      unsup: 1'b0
   };

   isx_regs_t s_reg;
   isx_regs_t s_next;
   logic [7:0] result;

   // ****************************************
   // Decoder
   // ****************************************
   isx_dec_if dec ();
   assign dec.instr = INSTR_IN;

   isx_decode u_decode (
      .dec (dec)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_next       = s_reg;
      s_next.we    = 1'b0;
      s_next.flush = 1'b0;
      s_next.done  = 1'b0;
      s_next.unsup = 1'b0;
      result       = 8'h00;
      if (INSTR_VALID_IN) begin
         case (s_reg.state)
            isx_pkg::ST_SKIP: begin
               // Prefetched word is dropped: this cycle is the no-operation
               s_next.state = isx_pkg::ST_RUN; //RL2
               s_next.done  = 1'b1;
            end
            isx_pkg::ST_RUN: begin
               case (dec.op)
                  isx_pkg::OP_INC: begin
                     result = FILE_DATA_IN + isx_pkg::ONE; //RL1
                     if (dec.dir) begin //RL1
                        s_next.we    = 1'b1;
                        s_next.waddr = dec.addr;
                        s_next.wdata = result;
                     end else begin
                        s_next.acc = result;
                     end
                     if (isx_pkg::f_is_zero(result)) begin //RL2
                        s_next.flush = 1'b1;
                        s_next.state = isx_pkg::ST_SKIP;
                     end else begin
                        s_next.done = 1'b1;
                     end
                  end
                  isx_pkg::OP_OR: begin
                     result = s_reg.acc | FILE_DATA_IN; //RL4
                     if (dec.dir) begin //RL4
                        s_next.we    = 1'b1;
                        s_next.waddr = dec.addr;
                        s_next.wdata = result;
                     end else begin
                        s_next.acc = result;
                     end
                     s_next.zero = isx_pkg::f_is_zero(result); //RL8
                     s_next.done = 1'b1; //RL5
                  end
                  isx_pkg::OP_LIT: begin
                     s_next.acc  = dec.lit; //RL6
                     s_next.done = 1'b1; //RL7
                  end
                  default: begin
                     // Other opcodes belong to other execute units
                     s_next.unsup = 1'b1;
                  end
               endcase
            end
            default: begin
               s_next.state = isx_pkg::ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         s_reg <= REGS_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign FILE_WE_OUT     = s_reg.we;
   assign FILE_WADDR_OUT  = s_reg.waddr;
   assign FILE_WDATA_OUT  = s_reg.wdata;
   assign ACC_OUT         = s_reg.acc;
   assign ZERO_FLAG_OUT   = s_reg.zero;
   assign FLUSH_OUT       = s_reg.flush;
   assign DONE_OUT        = s_reg.done;
   assign UNSUPPORTED_OUT = s_reg.unsup;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);

   logic run_valid;
   assign run_valid = INSTR_VALID_IN && (s_reg.state == isx_pkg::ST_RUN);

   sequence s_inc_acc;
      run_valid && (INSTR_IN[13:8] == 6'h0f) && !INSTR_IN[7];
   endsequence

   sequence s_inc_file;
      run_valid && (INSTR_IN[13:8] == 6'h0f) && INSTR_IN[7];
   endsequence

   sequence s_inc_wraps;
      run_valid && (INSTR_IN[13:8] == 6'h0f) && (FILE_DATA_IN == 8'hff);
   endsequence

   sequence s_or_acc;
      run_valid && (INSTR_IN[13:8] == 6'h04) && !INSTR_IN[7];
   endsequence

   sequence s_load;
      run_valid && (INSTR_IN[13:10] == 4'hc);
   endsequence

   // Skip waits for the next valid word, so the no-op shows one cycle after that word
   sequence s_skip_then_valid;
      s_inc_wraps ##1 INSTR_VALID_IN;
   endsequence

   sequence s_noop_cycle;
      !FILE_WE_OUT && DONE_OUT && !FLUSH_OUT;
   endsequence

   AST_INC_TO_ACC: assert property ( //RL1
      s_inc_acc |=> (ACC_OUT == 8'($past(FILE_DATA_IN) + 8'h01)) && !FILE_WE_OUT)
      else $error("increment to accumulator wrong");

   AST_INC_TO_FILE: assert property ( //RL1
      s_inc_file |=> FILE_WE_OUT && (FILE_WADDR_OUT == $past(INSTR_IN[6:0]))
         && (FILE_WDATA_OUT == 8'($past(FILE_DATA_IN) + 8'h01)) && $stable(ACC_OUT))
      else $error("increment to file register wrong");

   AST_INC_NO_FLAG: assert property ( //RL1
      (s_inc_acc or s_inc_file) |=> $stable(ZERO_FLAG_OUT))
      else $error("increment touched the zero flag");

   AST_SKIP_TWO_CYCLES: assert property ( //RL2
      s_inc_wraps |=> FLUSH_OUT && !DONE_OUT && (s_reg.state == isx_pkg::ST_SKIP))
      else $error("zero result did not skip the prefetched word");

   AST_SKIP_NOOP: assert property ( //RL2
      s_skip_then_valid |=> s_noop_cycle)
      else $error("discarded word was not run as a no-operation");

   AST_NO_SKIP: assert property ( //RL2
      run_valid && (INSTR_IN[13:8] == 6'h0f) && (FILE_DATA_IN != 8'hff)
         |=> !FLUSH_OUT && DONE_OUT)
      else $error("nonzero increment skipped");

   AST_OR_RESULT: assert property ( //RL4
      s_or_acc |=> (ACC_OUT == ($past(ACC_OUT) | $past(FILE_DATA_IN)))
         && (ZERO_FLAG_OUT == (ACC_OUT == 8'h00)))
      else $error("OR into accumulator or its zero flag wrong");

   AST_OR_ONE_CYCLE: assert property ( //RL5
      run_valid && (INSTR_IN[13:8] == 6'h04)
         |=> DONE_OUT && !FLUSH_OUT && (s_reg.state == isx_pkg::ST_RUN))
      else $error("OR did not complete in one cycle");

   AST_LOAD_LITERAL: assert property ( //RL6
      s_load |=> (ACC_OUT == $past(INSTR_IN[7:0])) && $stable(ZERO_FLAG_OUT) && DONE_OUT)
      else $error("literal load wrong");

   AST_ZERO_FLAG: assert property ( //RL8
      run_valid && (INSTR_IN[13:8] == 6'h04) && INSTR_IN[7]
         |=> ZERO_FLAG_OUT == (FILE_WDATA_OUT == 8'h00))
      else $error("zero flag disagrees with OR result");

endmodule
`default_nettype wire

/* tb/isx_file_model.sv */
// File register array and fetch data path seen by the execute block
`timescale 1ns/1ps
`default_nettype none
module isx_file_model (
   // Fetch side
   input  wire logic       clk_in,
   input  wire logic       valid_in,
   input  wire logic [6:0] addr_in,
   output logic [7:0]      data_out,
   // Write port
   input  wire logic       we_in,
   input  wire logic [6:0] waddr_in,
   input  wire logic [7:0] wdata_in
);
   logic [7:0] mem [128];
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
   end
   // Outside an instruction cycle the read path is not held, so show garbage
   assign data_out = valid_in ? mem[addr_in] : ~mem[addr_in];
   always @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end
endmodule
`default_nettype wire

/* tb/tb_incr_skip_or_literal_exec.sv */
// Self-checking bench for the execute block
`timescale 1ns/1ps
`default_nettype none
module tb_incr_skip_or_literal_exec;
   logic        clk, rst_n, valid, we, flush, done, unsup, zf;
   logic [13:0] instr;
   logic [7:0]  fdata, wdata, acc;
   logic [6:0]  waddr;
   int          n_errors = 0;
   int          n_checks = 0;
   isx_exec uut (.CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(valid),
      .INSTR_IN(instr), .FILE_DATA_IN(fdata), .FILE_WE_OUT(we),
      .FILE_WADDR_OUT(waddr), .FILE_WDATA_OUT(wdata), .ACC_OUT(acc),
      .ZERO_FLAG_OUT(zf), .FLUSH_OUT(flush), .DONE_OUT(done),
      .UNSUPPORTED_OUT(unsup));
   isx_file_model model (.clk_in(clk), .valid_in(valid), .addr_in(instr[6:0]),
      .data_out(fdata), .we_in(we), .waddr_in(waddr), .wdata_in(wdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string m);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %b want %b", $time, m, got, exp);
      end
   endtask
   // One instruction cycle; nv/nw is what the fetch side shows next
   task automatic put(input logic [13:0] w, input logic nv, input logic [13:0] nw);
      @(posedge clk);
      valid <= 1'b1;
      instr <= w;
      @(posedge clk);
      valid <= nv;
      instr <= nw;
      #1;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_or;
      model.mem[5] = 8'h13;
      model.mem[6] = 8'h00;
      model.mem[7] = 8'h40;
      put(14'h3091, 1'b0, 14'h0000);
      put({6'h04, 1'b0, 7'h05}, 1'b0, 14'h0000);
      chk8(acc, 8'h93, "or acc");
      chk1(zf, 1'b0, "or z");
      chk1(done, 1'b1, "or done");
      put({6'h04, 1'b1, 7'h07}, 1'b0, 14'h0000);
      chk1(we, 1'b1, "or we");
      chk8({1'b0, waddr}, 8'h07, "or waddr");
      chk8(wdata, 8'hd3, "or wdata");
      chk8(acc, 8'h93, "or acc kept");
      put(14'h3000, 1'b0, 14'h0000);
      put({6'h04, 1'b0, 7'h06}, 1'b0, 14'h0000);
      chk1(zf, 1'b1, "or z set");
   endtask
   task automatic t_load;
      logic [7:0] lit [3] = '{8'h00, 8'h5a, 8'hff};
      for (int i = 0; i < 3; i++) begin
         put({4'hc, 2'(i), lit[i]}, 1'b0, 14'h0000);
         chk8(acc, lit[i], "lit acc");
         chk1(zf, 1'b1, "lit z");
         chk1(done, 1'b1, "lit done");
      end
   endtask
   task automatic t_inc;
      model.mem[0] = 8'h7f;
      put({6'h0f, 1'b0, 7'h00}, 1'b0, 14'h0000);
      chk8(acc, 8'h80, "inc acc");
      chk1(zf, 1'b1, "inc z");
      chk1(flush, 1'b0, "inc flush");
      chk1(done, 1'b1, "inc done");
      chk1(we, 1'b0, "inc we");
   endtask
   task automatic t_skip;
      model.mem[127] = 8'hff;
      put({6'h0f, 1'b1, 7'h7f}, 1'b1, 14'h3033);
      chk1(we, 1'b1, "skip we");
      chk8({1'b0, waddr}, 8'h7f, "skip waddr");
      chk8(wdata, 8'h00, "skip wdata");
      chk1(flush, 1'b1, "skip flush");
      chk1(done, 1'b0, "skip early");
      chk1(zf, 1'b1, "skip z");
      @(posedge clk);
      valid <= 1'b0;
      #1;
      chk1(done, 1'b1, "skip done");
      chk8(acc, 8'h80, "skip dropped");
      chk8(model.mem[127], 8'h00, "skip mem");
   endtask
   task automatic t_unsup;
      logic [13:0] w [3] = '{14'h3d5a, 14'h0e05, 14'h0505};
      for (int i = 0; i < 3; i++) begin
         put(w[i], 1'b0, 14'h0000);
         chk1(unsup, 1'b1, "unsup");
         chk1(done, 1'b0, "unsup done");
         chk8(acc, 8'h80, "unsup acc");
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      valid = 1'b0;
      instr = 14'h0000;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk8(acc, 8'h00, "rst acc");
      chk1(zf, 1'b0, "rst z");
      t_or();
      t_load();
      t_inc();
      t_skip();
      t_unsup();
      give_verdict();
   end
   // Whole run needs about 40 cycles
   initial begin
      repeat (1000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
